// ==== core/fsp_pkg.sv ====
package fsp_pkg;

  // Array geometry
  localparam int unsigned ADDR_W      = 21;
  localparam logic [20:0] ARRAY_LAST  = 21'h1fffff;
  localparam logic [4:0]  BLOCK_BASE  = 5'h0f;
  localparam logic [4:0]  SECTOR_BASE = 5'h0b;
  localparam logic [4:0]  SECTOR_CAP  = 5'h0f;

  // Instruction codes
  localparam logic [7:0] OP_WREN    = 8'h06;
  localparam logic [7:0] OP_WRDI    = 8'h04;
  localparam logic [7:0] OP_RDSR_LO = 8'h05;
  localparam logic [7:0] OP_RDSR_HI = 8'h35;
  localparam logic [7:0] OP_WRSR    = 8'h01;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME  = 8'h7a;

  // Status bit positions
  localparam int unsigned POS_BUSY = 0;
  localparam int unsigned POS_WEL  = 1;
  localparam int unsigned POS_BP0  = 2;
  localparam int unsigned POS_TB   = 5;
  localparam int unsigned POS_GRAN = 6;
  localparam int unsigned POS_SPL  = 7;
  localparam int unsigned POS_SPU  = 8;
  localparam int unsigned POS_QE   = 9;
  localparam int unsigned POS_LK1  = 11;
  localparam int unsigned POS_CMP  = 14;
  localparam int unsigned POS_SUS  = 15;

  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // Link bit counter saturates so long frames read as misaligned
  localparam int unsigned CNT_W   = 6;
  localparam logic [5:0]  CNT_SAT = 6'h3f;
  localparam int unsigned SYNC_N  = 3;

  typedef enum logic [1:0] {
    SRP_SOFTWARE = 2'b00,
    SRP_HARDWARE = 2'b01,
    SRP_LOCKDOWN = 2'b10,
    SRP_ONE_TIME = 2'b11
  } fsp_srp_mode_t;

  typedef struct packed {
    logic       suspend_flag;
    logic       complement_protect;
    logic [2:0] security_lock;
    logic       reserved_s10;
    logic       quad_enable;
    logic       status_protect_upper;
    logic       status_protect_lower;
    logic       granularity_select;
    logic       top_bottom_select;
    logic [2:0] block_protect;
    logic       write_enable_latch;
    logic       busy;
  } fsp_status_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] data_lo;
    logic [7:0] data_hi;
    logic [5:0] bit_count;
  } fsp_link_cmd_t;

  typedef struct packed {
    logic        none;
    logic [20:0] lo;
    logic [20:0] hi;
  } fsp_range_t;

endpackage

// ==== core/fsp_prot_decode.sv ====
`timescale 1ns/100ps
`default_nettype none
module fsp_prot_decode (
  input  wire logic [2:0]         block_protect_i,
  input  wire logic               top_bottom_i,
  input  wire logic               granularity_i,
  input  wire logic               complement_i,
  output fsp_pkg::fsp_range_t     range_o
);

  logic        code_none;
  logic        code_all;
  logic [4:0]  size_log2;
  logic [20:0] mask;
  logic [20:0] top_lo;

  assign code_none = (block_protect_i == 3'h0);
  assign code_all  = (block_protect_i[2:1] == 2'h3);
  // Sector mode caps at 32KB, ignoring the lowest code bit
  assign size_log2 = granularity_i
                   ? (block_protect_i[2] ? fsp_pkg::SECTOR_CAP
                      : fsp_pkg::SECTOR_BASE + {2'h0, block_protect_i})
                   : fsp_pkg::BLOCK_BASE + {2'h0, block_protect_i};
  assign mask   = (21'h000001 << size_log2) - 21'h000001;
  assign top_lo = ~mask;

  always_comb
  begin
    range_o.none = 1'b0;
    range_o.lo   = 21'h000000;
    range_o.hi   = fsp_pkg::ARRAY_LAST;
    if (!complement_i)
    begin
      if (code_none)
        range_o.none = 1'b1;
      else if (!code_all && top_bottom_i)
        range_o.hi = mask;
      else if (!code_all)
        range_o.lo = top_lo;
    end
    else
    begin
      // Complement of an end-anchored piece is the other end
      if (code_all)
        range_o.none = 1'b1;
      else if (!code_none && top_bottom_i)
        range_o.lo = mask + 21'h000001;
      else if (!code_none)
        range_o.hi = top_lo - 21'h000001;
    end
  end

endmodule
`default_nettype wire

// ==== core/fsp_spi_link.sv ====
`timescale 1ns/100ps
`default_nettype none
module fsp_spi_link (
  input  wire logic                  sck_i,
  input  wire logic                  cs_n_i,
  input  wire logic                  resetn_i,
  input  wire logic                  mosi_i,
  input  wire fsp_pkg::fsp_status_t  status_i,
  output fsp_pkg::fsp_link_cmd_t     cmd_o,
  output logic                       miso_o,
  output logic                       miso_oe_n_o
);

  logic       first_r;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [7:0] op_r;
  logic [7:0] d0_r;
  logic [7:0] d1_r;
  logic       byte_done;
  logic       is_read;
  logic [7:0] rd_byte;

  assign cnt_nxt   = first_r ? 6'h01
                   : (cnt_r == fsp_pkg::CNT_SAT ? cnt_r : cnt_r + 6'h01);
  assign sh_nxt    = {(first_r ? 7'h00 : sh_r[6:0]), mosi_i};
  assign byte_done = (cnt_nxt[2:0] == 3'h0);
  assign is_read   = (op_r == fsp_pkg::OP_RDSR_LO) || (op_r == fsp_pkg::OP_RDSR_HI);
  assign rd_byte   = (op_r == fsp_pkg::OP_RDSR_HI) ? status_i[15:8] : status_i[7:0];

  // Serial clock stops between frames; chip select marks each start
  always_ff @(posedge sck_i or posedge cs_n_i)
  begin
    if (cs_n_i)
      first_r <= 1'b1;
    else
      first_r <= 1'b0;
  end

  // Captured frame is kept after chip select rises for the core to take
  always_ff @(posedge sck_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cnt_r <= 6'h00;
      sh_r  <= 8'h00;
      op_r  <= 8'h00;
      d0_r  <= 8'h00;
      d1_r  <= 8'h00;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      sh_r  <= sh_nxt;
      if (byte_done && cnt_nxt[5:3] == 3'h1)
        op_r <= sh_nxt;
      if (byte_done && cnt_nxt[5:3] == 3'h2)
        d0_r <= sh_nxt;
      if (byte_done && cnt_nxt[5:3] == 3'h3)
        d1_r <= sh_nxt;
    end
  end

  // Command writes to status land only between frames; busy, power-cycle and done inputs can still alter it mid-frame
  always_ff @(negedge sck_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      miso_o      <= 1'b0;
      miso_oe_n_o <= 1'b1;
    end
    else if (cnt_r >= 6'h08 && is_read)
    begin
      miso_o      <= rd_byte[~cnt_r[2:0]];
      miso_oe_n_o <= 1'b0;
    end
  end

  assign cmd_o.opcode    = op_r;
  assign cmd_o.data_lo   = d0_r;
  assign cmd_o.data_hi   = d1_r;
  assign cmd_o.bit_count = cnt_r;

endmodule
`default_nettype wire

// ==== core/fsp_status_protect.sv ====
`timescale 1ns/100ps
`default_nettype none
module fsp_status_protect (
  input  wire logic                  core_clk_i,
  input  wire logic                  resetn_i,
  input  wire logic                  power_cycle_i,
  input  wire logic                  busy_i,
  input  wire logic                  sck_i,
  input  wire logic                  cs_n_i,
  input  wire logic                  mosi_i,
  input  wire logic                  wp_n_i,
  input  wire logic                  chk_req_i,
  input  wire logic [23:0]           chk_start_i,
  input  wire logic [23:0]           chk_end_i,
  input  wire logic                  pe_done_i,
  output logic                       miso_o,
  output logic                       miso_oe_n_o,
  output fsp_pkg::fsp_status_t       status_o,
  output fsp_pkg::fsp_range_t        prot_range_o,
  output logic                       quad_enable_o,
  output logic [2:0]                 sec_lock_o,
  output logic                       chk_done_o,
  output logic                       chk_allow_o,
  output logic                       wrsr_reject_o
);

  fsp_pkg::fsp_status_t   status_r;
  fsp_pkg::fsp_status_t   status_nxt;
  fsp_pkg::fsp_range_t    range_now;
  fsp_pkg::fsp_range_t    range_r;
  fsp_pkg::fsp_link_cmd_t link_cmd;
  fsp_pkg::fsp_srp_mode_t srp_mode;

  logic [2:0]  cs_sync_r;
  logic        cs_filt_r;
  logic [2:0]  wp_sync_r;
  logic        wp_filt_r;
  logic        frame_end;

  logic        aligned;
  logic [2:0]  nbytes;
  logic        do_wren;
  logic        do_wrdi;
  logic        do_wrsr;
  logic        do_susp;
  logic        do_resume;
  logic        wrsr_ok;
  logic        wp_high;
  logic [15:0] wdata;

  logic [20:0] chk_lo;
  logic [20:0] chk_hi;
  logic        overlap;

  logic        chk_done_r;
  logic        chk_allow_r;
  logic        reject_r;

  function automatic logic cmd_is(input fsp_pkg::fsp_link_cmd_t c,
                                  input logic [7:0]              op,
                                  input logic [2:0]              len);
    cmd_is = (c.bit_count[2:0] == 3'h0) && (c.bit_count[5:3] == len)
             && (c.opcode == op);
  endfunction

  fsp_spi_link u_link (
    .sck_i       (sck_i),
    .cs_n_i      (cs_n_i),
    .resetn_i    (resetn_i),
    .mosi_i      (mosi_i),
    .status_i    (status_r),
    .cmd_o       (link_cmd),
    .miso_o      (miso_o),
    .miso_oe_n_o (miso_oe_n_o)
  );

  fsp_prot_decode u_decode (
    .block_protect_i (status_r.block_protect),
    .top_bottom_i    (status_r.top_bottom_select),
    .granularity_i   (status_r.granularity_select),
    .complement_i    (status_r.complement_protect),
    .range_o         (range_now)
  );

  // Pins pass three flops; a level counts once stages two and three agree
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cs_sync_r <= 3'h7;
      cs_filt_r <= 1'b1;
      wp_sync_r <= 3'h7;
      wp_filt_r <= 1'b1;
    end
    else
    begin
      cs_sync_r <= {cs_sync_r[1:0], cs_n_i};
      wp_sync_r <= {wp_sync_r[1:0], wp_n_i};
      if (cs_sync_r[1] == cs_sync_r[2])
        cs_filt_r <= cs_sync_r[2];
      if (wp_sync_r[1] == wp_sync_r[2])
        wp_filt_r <= wp_sync_r[2];
    end
  end

  // Frame contents are stable once chip select is high; the link clock has stopped
  assign frame_end = !cs_filt_r && cs_sync_r[1] && cs_sync_r[2];

  assign aligned   = (link_cmd.bit_count[2:0] == 3'h0);
  assign nbytes    = link_cmd.bit_count[5:3];
  assign do_wren   = frame_end && cmd_is(link_cmd, fsp_pkg::OP_WREN, 3'h1);
  assign do_wrdi   = frame_end && cmd_is(link_cmd, fsp_pkg::OP_WRDI, 3'h1);
  assign do_susp   = frame_end && cmd_is(link_cmd, fsp_pkg::OP_SUSPEND, 3'h1);
  assign do_resume = frame_end && cmd_is(link_cmd, fsp_pkg::OP_RESUME, 3'h1);
  // One data byte writes the low half only; two write both halves
  assign do_wrsr   = frame_end && aligned && (nbytes == 3'h2 || nbytes == 3'h3)
                     && (link_cmd.opcode == fsp_pkg::OP_WRSR);
  assign wdata     = {(nbytes == 3'h3) ? link_cmd.data_hi : status_r[15:8],
                      link_cmd.data_lo};

  assign srp_mode  = fsp_pkg::fsp_srp_mode_t'({status_r.status_protect_upper,
                                               status_r.status_protect_lower});
  // With quad mode the pin is a data line, so its protect role is dropped
  assign wp_high   = wp_filt_r || status_r.quad_enable;

  always_comb
  begin
    wrsr_ok = 1'b0;
    case (srp_mode)
      fsp_pkg::SRP_SOFTWARE: wrsr_ok = status_r.write_enable_latch;
      fsp_pkg::SRP_HARDWARE: wrsr_ok = status_r.write_enable_latch && wp_high;
      fsp_pkg::SRP_LOCKDOWN: wrsr_ok = 1'b0;
      fsp_pkg::SRP_ONE_TIME: wrsr_ok = 1'b0;
      default:               wrsr_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    status_nxt      = status_r;
    status_nxt.busy = busy_i;
    if (do_wrsr && wrsr_ok)
    begin
      status_nxt.status_protect_lower = wdata[fsp_pkg::POS_SPL];
      status_nxt.granularity_select   = wdata[fsp_pkg::POS_GRAN];
      status_nxt.top_bottom_select    = wdata[fsp_pkg::POS_TB];
      status_nxt.block_protect        = wdata[fsp_pkg::POS_BP0 +: 3];
      status_nxt.status_protect_upper = wdata[fsp_pkg::POS_SPU];
      status_nxt.quad_enable          = wdata[fsp_pkg::POS_QE];
      status_nxt.complement_protect   = wdata[fsp_pkg::POS_CMP];
      // Lock bits only ever accumulate ones
      status_nxt.security_lock = status_r.security_lock
                                 | wdata[fsp_pkg::POS_LK1 +: 3];
    end
    // Power loss drops volatile state and releases lock-down only
    if (power_cycle_i)
    begin
      status_nxt.suspend_flag       = 1'b0;
      status_nxt.write_enable_latch = 1'b0;
      if (srp_mode == fsp_pkg::SRP_LOCKDOWN)
      begin
        status_nxt.status_protect_upper = 1'b0;
        status_nxt.status_protect_lower = 1'b0;
      end
    end
    // Clears first, then sets, so a coincident set is not lost
    if (do_wrdi || do_wrsr || pe_done_i)
      status_nxt.write_enable_latch = 1'b0;
    if (do_resume)
      status_nxt.suspend_flag = 1'b0;
    if (do_wren)
      status_nxt.write_enable_latch = 1'b1;
    if (do_susp)
      status_nxt.suspend_flag = 1'b1;
  end

  // Factory defaults load whenever resetn_i is low; bits then persist
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      status_r <= fsp_pkg::STATUS_RESET;
    else
      status_r <= status_nxt;
  end

  assign chk_lo  = chk_start_i[fsp_pkg::ADDR_W-1:0];
  assign chk_hi  = chk_end_i[fsp_pkg::ADDR_W-1:0];
  assign overlap = !range_now.none && (chk_lo <= range_now.hi)
                   && (chk_hi >= range_now.lo);

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      range_r     <= '{none: 1'b1, lo: 21'h000000, hi: 21'h000000};
      chk_done_r  <= 1'b0;
      chk_allow_r <= 1'b0;
      reject_r    <= 1'b0;
    end
    else
    begin
      range_r     <= range_now;
      chk_done_r  <= chk_req_i;
      chk_allow_r <= chk_req_i && !overlap;
      reject_r    <= do_wrsr && !wrsr_ok;
    end
  end

  assign status_o      = status_r;
  assign prot_range_o  = range_r;
  assign quad_enable_o = status_r.quad_enable;
  assign sec_lock_o    = status_r.security_lock;
  assign chk_done_o    = chk_done_r;
  assign chk_allow_o   = chk_allow_r;
  assign wrsr_reject_o = reject_r;

endmodule
`default_nettype wire

// ==== sim/fsp_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module fsp_host_model (
  output logic     sck_o,
  output logic     cs_n_o,
  output logic     mosi_o,
  input wire logic miso_i
);
  initial
  begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // Mode 0, MSB first; the serial clock only runs inside a frame
  task automatic xfer(input logic [23:0] d, input int n, output logic [7:0] rd);
    rd = 8'h00;
    #3 cs_n_o = 1'b0;
    for (int i = 0; i < n * 8; i++)
    begin
      mosi_o = d[23 - i];
      #16 sck_o = 1'b1;
      if (i >= 8)
        rd = {rd[6:0], miso_i};
      #16 sck_o = 1'b0;
    end
    #16 cs_n_o = 1'b1;
    // Released line flips so a stale bit cannot look valid
    mosi_o = ~mosi_o;
    // Long idle gap so the core has finished with the frame
    #600;
  endtask
endmodule
`default_nettype wire

// ==== sim/fsp_status_protect_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module fsp_status_protect_monitor (
  input wire logic                 core_clk_i,
  input wire logic                 resetn_i,
  input wire logic                 power_cycle_i,
  input wire logic                 pe_done_i,
  input wire logic                 chk_req_i,
  input wire logic [23:0]          chk_start_i,
  input wire logic [23:0]          chk_end_i,
  input wire fsp_pkg::fsp_status_t status_o,
  input wire fsp_pkg::fsp_range_t  prot_range_o,
  input wire logic [2:0]           sec_lock_o,
  input wire logic                 chk_done_o,
  input wire logic                 chk_allow_o,
  input wire logic                 wrsr_reject_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  wire logic [1:0] srp_w = {status_o.status_protect_upper, status_o.status_protect_lower};

  property p_chk_done;
    chk_req_i |=> chk_done_o;
  endproperty
  a_chk_done: assert property (p_chk_done) else $error("check answer missing");
  property p_chk_idle;
    !chk_req_i |=> !chk_done_o;
  endproperty
  a_chk_idle: assert property (p_chk_idle) else $error("check answer unasked");
  property p_chk_allow;
    chk_req_i |=> chk_allow_o == ($past(prot_range_o.none) ||
      $past(chk_end_i[20:0]) < $past(prot_range_o.lo) ||
      $past(chk_start_i[20:0]) > $past(prot_range_o.hi));
  endproperty
  a_chk_allow: assert property (p_chk_allow) else $error("overlap verdict wrong");
  property p_lock_sticky;
    1'b1 |=> (sec_lock_o & $past(sec_lock_o)) == $past(sec_lock_o);
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared");
  property p_otp_hold;
    srp_w == 2'b11 |=> srp_w == 2'b11;
  endproperty
  a_otp_hold: assert property (p_otp_hold) else $error("permanent lock left");
  property p_lockdown_hold;
    srp_w == 2'b10 && !power_cycle_i |=> srp_w == 2'b10;
  endproperty
  a_lockdown_hold: assert property (p_lockdown_hold) else $error("lock-down left");
  property p_lockdown_release;
    srp_w == 2'b10 && power_cycle_i |=> srp_w == 2'b00;
  endproperty
  a_lockdown_release: assert property (p_lockdown_release) else $error("no release");
  property p_pe_wel;
    pe_done_i |=> !status_o.write_enable_latch;
  endproperty
  a_pe_wel: assert property (p_pe_wel) else $error("latch kept after done");

  c_allow: cover property (chk_req_i ##1 chk_allow_o);
  c_reject: cover property (wrsr_reject_o);
  c_release: cover property (srp_w == 2'b10 && power_cycle_i);
endmodule

bind fsp_status_protect fsp_status_protect_monitor i_fsp_status_protect_monitor (
  .core_clk_i, .resetn_i, .power_cycle_i, .pe_done_i, .chk_req_i, .chk_start_i, .chk_end_i,
  .status_o, .prot_range_o, .sec_lock_o, .chk_done_o, .chk_allow_o, .wrsr_reject_o
);
`default_nettype wire

// ==== sim/test_flash_status_write_protection.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("FAIL %0t got %h exp %h", $time, g, e); end end
module test_flash_status_write_protection;
  logic                 core_clk_i, resetn_i, power_cycle_i, busy_i, wp_n_i;
  logic                 chk_req_i, pe_done_i, none;
  logic [23:0]          chk_start_i, chk_end_i;
  wire logic            sck_i, cs_n_i, mosi_i, miso_o, miso_oe_n_o;
  wire logic            miso_pin = miso_oe_n_o ? 1'bz : miso_o;
  wire logic            quad_enable_o, chk_done_o, chk_allow_o, wrsr_reject_o;
  wire logic [2:0]      sec_lock_o;
  fsp_pkg::fsp_status_t status_o;
  fsp_pkg::fsp_range_t  prot_range_o;
  int                   fail_count, checks_done, seed, lo, hi;
  logic [15:0]          mdl;
  logic [7:0]           rd;
  logic [31:0]          r;
  logic                 rej_seen;

  // Reject is a one-cycle pulse; latch it so a frame-level check can see it
  always @(posedge core_clk_i)
    if (wrsr_reject_o === 1'b1)
      rej_seen <= 1'b1;

  fsp_status_protect i_fsp_status_protect (
    .core_clk_i, .resetn_i, .power_cycle_i, .busy_i, .sck_i, .cs_n_i, .mosi_i, .wp_n_i,
    .chk_req_i, .chk_start_i, .chk_end_i, .pe_done_i, .miso_o, .miso_oe_n_o, .status_o,
    .prot_range_o, .quad_enable_o, .sec_lock_o, .chk_done_o, .chk_allow_o, .wrsr_reject_o
  );
  fsp_host_model i_fsp_host_model (
    .sck_o(sck_i), .cs_n_o(cs_n_i), .mosi_o(mosi_i), .miso_i(miso_pin)
  );

  initial
  begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  task automatic results;
    $display("Mismatches %0d, comparisons %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic xf(input logic [23:0] d, input int n);
    i_fsp_host_model.xfer(d, n, rd);
  endtask

  task automatic wrsr(input logic [15:0] v);
    logic ok;
    xf({fsp_pkg::OP_WREN, 16'h0}, 1);
    mdl[1] = 1'b1;
    `CHK(status_o, mdl)
    rej_seen = 1'b0;
    xf({fsp_pkg::OP_WRSR, v[7:0], v[15:8]}, 3);
    ok = !mdl[8] && !(mdl[7] && !wp_n_i && !mdl[9]);
    if (ok)
      mdl = {mdl[15], v[14], mdl[13:11] | v[13:11], 1'b0, v[9:2], mdl[1:0]};
    mdl[1] = 1'b0;
    `CHK(status_o, mdl)
    `CHK(rej_seen, !ok)
    `CHK(quad_enable_o, mdl[9])
    `CHK(miso_oe_n_o, 1'b1)
  endtask

  task automatic pcycle;
    @(negedge core_clk_i);
    power_cycle_i = 1'b1;
    @(negedge core_clk_i);
    power_cycle_i = 1'b0;
    @(negedge core_clk_i);
    mdl[15] = 1'b0;
    mdl[1] = 1'b0;
    if (mdl[8:7] == 2'b10)
      mdl[8:7] = 2'b00;
    `CHK(status_o, mdl)
  endtask

  task automatic rng_chk;
    int sz, s, e;
    logic all;
    sz = (mdl[6] ? 'h1000 : 'h10000) << (mdl[6] && mdl[4] ? 3 : mdl[4:2] - 3'h1);
    none = mdl[4:2] == 3'h0;
    all = mdl[4:3] == 2'b11;
    lo = all || mdl[5] ? 0 : 'h200000 - sz;
    hi = !all && mdl[5] ? sz - 1 : 'h1fffff;
    if (mdl[14])
    begin
      {lo, hi} = none || all ? {32'h0, 32'h1fffff} :
        lo == 0 ? {hi + 1, 32'h1fffff} : {32'h0, lo - 1};
      none = all;
    end
    `CHK(prot_range_o.none, none)
    if (!none)
      `CHK({prot_range_o.lo, prot_range_o.hi}, {lo[20:0], hi[20:0]})
    for (int k = 0; k < 2; k++)
    begin
      s = k ? lo : {$random(seed)} % 'h1ff000;
      e = k ? lo : s + {$random(seed)} % 'h1000;
      @(negedge core_clk_i);
      chk_start_i = s[23:0];
      chk_end_i = e[23:0];
      chk_req_i = 1'b1;
      @(negedge core_clk_i);
      chk_req_i = 1'b0;
      `CHK(chk_done_o, 1'b1)
      `CHK(chk_allow_o, none || e < lo || s > hi)
    end
  endtask

  initial
  begin
    #2000000;
    fail_count++;
    results;
  end

  initial
  begin
    {seed, fail_count, checks_done} = {32'd81, 32'd0, 32'd0};
    {resetn_i, power_cycle_i, busy_i, chk_req_i, pe_done_i, wp_n_i} = 6'h01;
    {chk_start_i, chk_end_i} = 48'h0;
    mdl = fsp_pkg::STATUS_RESET;
    repeat (10) @(negedge core_clk_i);
    resetn_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    `CHK(status_o, mdl)
    rng_chk;
    xf({fsp_pkg::OP_WRSR, 16'h5c40}, 3);
    `CHK(status_o, mdl)
    r = $random(seed);
    wrsr(r[15:0] & 16'h427c);
    xf({fsp_pkg::OP_RDSR_LO, 16'h0}, 2);
    `CHK(rd, mdl[7:0])
    xf({fsp_pkg::OP_RDSR_HI, 16'h0}, 2);
    `CHK(rd, mdl[15:8])
    for (int c = 0; c < 64; c++)
    begin
      wrsr({1'b0, c[5], 7'h0, c[4:0], 2'b00});
      rng_chk;
    end
    wp_n_i = 1'b0;
    wrsr(16'h0080);
    wrsr(16'h0084);
    wp_n_i = 1'b1;
    wrsr(16'h0284);
    wp_n_i = 1'b0;
    wrsr(16'h0288);
    wrsr(16'h0100);
    wrsr(16'h0000);
    pcycle;
    wrsr(16'h8800);
    wrsr(16'h3000);
    wrsr(16'h0000);
    `CHK(sec_lock_o, 3'h7)
    xf({fsp_pkg::OP_WREN, 16'h0}, 1);
    xf({fsp_pkg::OP_WRSR, 8'h08, 8'h00}, 2);
    mdl[7:0] = 8'h08;
    `CHK(status_o, mdl)
    xf({fsp_pkg::OP_WREN, 16'h0}, 1);
    xf({fsp_pkg::OP_WRDI, 16'h0}, 1);
    `CHK(status_o, mdl)
    @(negedge core_clk_i);
    busy_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    mdl[0] = 1'b1;
    `CHK(status_o, mdl)
    busy_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    mdl[0] = 1'b0;
    `CHK(status_o, mdl)
    xf({fsp_pkg::OP_SUSPEND, 16'h0}, 1);
    mdl[15] = 1'b1;
    `CHK(status_o, mdl)
    xf({fsp_pkg::OP_RESUME, 16'h0}, 1);
    mdl[15] = 1'b0;
    `CHK(status_o, mdl)
    xf({fsp_pkg::OP_SUSPEND, 16'h0}, 1);
    mdl[15] = 1'b1;
    pcycle;
    xf({fsp_pkg::OP_WREN, 16'h0}, 1);
    @(negedge core_clk_i);
    pe_done_i = 1'b1;
    @(negedge core_clk_i);
    pe_done_i = 1'b0;
    @(negedge core_clk_i);
    `CHK(status_o, mdl)
    wrsr(16'h0180);
    wrsr(16'h0000);
    pcycle;
    results;
  end
endmodule
`default_nettype wire
